// ### src/ctmc_map.svh
// Constants for the CAN transceiver mode control block.
// Assumes inclusion by bare name from design files.
`ifndef CTMC_MAP_SVH
`define CTMC_MAP_SVH

// ----------------------------------------
// Mode field encodings
// ----------------------------------------
`define CTMC_MODE_SLEEP_NOWAKE 2'h0
`define CTMC_MODE_LISTEN       2'h1
`define CTMC_MODE_SLEEP_WAKE   2'h2
`define CTMC_MODE_NORMAL       2'h3
`define CTMC_MODE_RESET        2'h0

`endif

// ### src/ctmc_pkg.sv
// Types for the CAN transceiver mode control block.
// Assumes the encodings written here match the map header.
package ctmc_pkg;

   typedef enum logic [1:0] {
      CTMC_SLEEP_NOWAKE = 2'h0,
      CTMC_LISTEN       = 2'h1,
      CTMC_SLEEP_WAKE   = 2'h2,
      CTMC_NORMAL       = 2'h3
   } ctmc_mode_t;

endpackage

// ### src/ctmc_sync.sv
// Two-stage synchroniser for one level from outside the clock domain.
// Assumes a single clock and an asynchronous active-low reset.
`timescale 1ns/1ps

module ctmc_sync
(
   input  wire logic clk_i,
   input  wire logic resetn_i,
   input  wire logic d_i,
   output logic      q_o
);

   logic meta_ff;
   logic q_ff;

   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         meta_ff <= 1'b0;
         q_ff    <= 1'b0;
      end
      else
      begin
         meta_ff <= d_i;
         q_ff    <= meta_ff;
      end
   end

   assign q_o = q_ff;

endmodule // ctmc_sync

// ### src/ctmc_top.sv
// CAN transceiver mode control: mode field, low-power-off handling,
// transmit/receive steering toward the bus driver and receiver.
// Assumes the mode field is written by the chip configuration logic on
// CLK_I, and pins (TXD, bus level) arrive asynchronously.
`timescale 1ns/1ps
`include "ctmc_map.svh"

module ctmc_top
(
   input  wire logic       CLK_I,
   input  wire logic       RESETN_I,
   input  wire logic [1:0] MODE_WDATA_I,
   input  wire logic       MODE_WE_I,
   input  wire logic       LOW_POWER_OFF_STATE_I,
   input  wire logic       TXD_I,
   input  wire logic       BUS_DOMINANT_I,
   output logic [1:0]      MODE_O,
   output logic [1:0]      ACTIVE_MODE_O,
   output logic            RXD_O,
   output logic            RXD_PULLDOWN_O,
   output logic            TXD_PULLUP_O,
   output logic            TXD_PULLDOWN_O,
   output logic            DRV_ON_O,
   output logic            RECV_ON_O,
   output logic            BUS_PULLDOWN_O,
   output logic            WAKE_CAPABLE_O
);

   // ----------------------------------------
   // Input synchronisers
   // ----------------------------------------
   logic txd_s;
   logic bus_dom_s;
   logic lpo_s;

   ctmc_sync u_sync_txd
   (
      .clk_i    (CLK_I),
      .resetn_i (RESETN_I),
      .d_i      (TXD_I),
      .q_o      (txd_s)
   );

   ctmc_sync u_sync_bus
   (
      .clk_i    (CLK_I),
      .resetn_i (RESETN_I),
      .d_i      (BUS_DOMINANT_I),
      .q_o      (bus_dom_s)
   );

   ctmc_sync u_sync_lpo
   (
      .clk_i    (CLK_I),
      .resetn_i (RESETN_I),
      .d_i      (LOW_POWER_OFF_STATE_I),
      .q_o      (lpo_s)
   );

   // ----------------------------------------
   // Mode field and low-power-off
   // ----------------------------------------
   // Configured field is kept untouched in low-power-off, so restore
   // on exit needs no saved copy.
   ctmc_pkg::ctmc_mode_t mode_ff;
   ctmc_pkg::ctmc_mode_t nxt_mode;
   ctmc_pkg::ctmc_mode_t act_mode;
   ctmc_pkg::ctmc_mode_t act_mode_ff;
   logic                 lpo_ff;

   always_comb
   begin
      nxt_mode = mode_ff;
      if (MODE_WE_I && !lpo_s)
      begin
         nxt_mode = ctmc_pkg::ctmc_mode_t'(MODE_WDATA_I);
      end
   end

   always_ff @(posedge CLK_I or negedge RESETN_I)
   begin
      if (!RESETN_I)
      begin
         mode_ff <= ctmc_pkg::ctmc_mode_t'(`CTMC_MODE_RESET);
      end
      else
      begin
         mode_ff <= nxt_mode;
      end
   end

   always_ff @(posedge CLK_I or negedge RESETN_I)
   begin
      if (!RESETN_I)
      begin
         lpo_ff <= 1'b0;
      end
      else
      begin
         lpo_ff <= lpo_s;
      end
   end

   always_comb
   begin
      act_mode = mode_ff;
      if (lpo_ff)
      begin
         if (mode_ff == ctmc_pkg::ctmc_mode_t'(`CTMC_MODE_SLEEP_NOWAKE))
         begin
            act_mode = ctmc_pkg::CTMC_SLEEP_NOWAKE;
         end
         else
         begin
            act_mode = ctmc_pkg::CTMC_SLEEP_WAKE;
         end
      end
   end

   // ----------------------------------------
   // Reported effective mode
   // ----------------------------------------
   // Registered beside the pin flops, so the reported mode and the
   // pins it steers change on the same edge.
   always_ff @(posedge CLK_I or negedge RESETN_I)
   begin
      if (!RESETN_I)
      begin
         act_mode_ff <= ctmc_pkg::ctmc_mode_t'(`CTMC_MODE_RESET);
      end
      else
      begin
         act_mode_ff <= act_mode;
      end
   end

   // ----------------------------------------
   // Pin and driver steering
   // ----------------------------------------
   logic drv_on_ff;
   logic rxd_ff;
   logic recv_on_ff;
   logic txd_pu_ff;
   logic sleep_ff;
   logic wake_ff;

   always_ff @(posedge CLK_I or negedge RESETN_I)
   begin
      if (!RESETN_I)
      begin
         drv_on_ff  <= 1'b0;
         rxd_ff     <= 1'b0;
         recv_on_ff <= 1'b0;
         txd_pu_ff  <= 1'b0;
         sleep_ff   <= 1'b1;
         wake_ff    <= 1'b0;
      end
      else
      begin
         unique case (act_mode)
            ctmc_pkg::CTMC_NORMAL:
            begin
               drv_on_ff  <= ~txd_s;
               rxd_ff     <= ~bus_dom_s;
               recv_on_ff <= 1'b1;
               txd_pu_ff  <= 1'b0;
               sleep_ff   <= 1'b0;
               wake_ff    <= 1'b0;
            end
            ctmc_pkg::CTMC_LISTEN:
            begin
               drv_on_ff  <= 1'b0;
               rxd_ff     <= ~bus_dom_s;
               recv_on_ff <= 1'b1;
               txd_pu_ff  <= 1'b1;
               sleep_ff   <= 1'b0;
               wake_ff    <= 1'b0;
            end
            ctmc_pkg::CTMC_SLEEP_WAKE:
            begin
               drv_on_ff  <= 1'b0;
               rxd_ff     <= 1'b0;
               recv_on_ff <= 1'b0;
               txd_pu_ff  <= 1'b0;
               sleep_ff   <= 1'b1;
               wake_ff    <= 1'b1;
            end
            ctmc_pkg::CTMC_SLEEP_NOWAKE:
            begin
               drv_on_ff  <= 1'b0;
               rxd_ff     <= 1'b0;
               recv_on_ff <= 1'b0;
               txd_pu_ff  <= 1'b0;
               sleep_ff   <= 1'b1;
               wake_ff    <= 1'b0;
            end
         endcase
      end
   end

   // Bus level is only trusted via the receiver; mode use before
   // programming is the host's concern
   assign MODE_O         = mode_ff;
   assign ACTIVE_MODE_O  = act_mode_ff;
   assign RXD_O          = rxd_ff;
   assign RXD_PULLDOWN_O = sleep_ff;
   assign TXD_PULLUP_O   = txd_pu_ff;
   assign TXD_PULLDOWN_O = sleep_ff;
   assign DRV_ON_O       = drv_on_ff;
   assign RECV_ON_O      = recv_on_ff;
   assign BUS_PULLDOWN_O = sleep_ff;
   assign WAKE_CAPABLE_O = wake_ff;

endmodule // ctmc_top

// ### verification/ctmc_props.sv
// Assertions on the mode control top ports.
// Assumes a bind onto ctmc_top; pins settle three edges after a TXD or bus change, four after a low-power-off change.
`timescale 1ns/1ps
module ctmc_props
(
   input wire logic       CLK_I,
   input wire logic       RESETN_I,
   input wire logic       LOW_POWER_OFF_STATE_I,
   input wire logic       TXD_I,
   input wire logic       BUS_DOMINANT_I,
   input wire logic [1:0] MODE_O,
   input wire logic [1:0] ACTIVE_MODE_O,
   input wire logic       RXD_O,
   input wire logic       TXD_PULLUP_O,
   input wire logic       DRV_ON_O,
   input wire logic       RECV_ON_O,
   input wire logic       BUS_PULLDOWN_O,
   input wire logic       WAKE_CAPABLE_O
);
   default clocking @(posedge CLK_I); endclocking
   default disable iff (!RESETN_I);
   // Reported mode and pins switch on one edge; pins lag their inputs by three
   drv_follow_a: assert property (
      (ACTIVE_MODE_O == 2'h3 && $past(ACTIVE_MODE_O) == 2'h3)
      |-> DRV_ON_O == !$past(TXD_I, 3)) else $error("driver level wrong");
   drv_only_a: assert property (
      DRV_ON_O |-> ACTIVE_MODE_O == 2'h3) else $error("driver on off normal");
   rxd_follow_a: assert property (
      (ACTIVE_MODE_O[0] && $past(ACTIVE_MODE_O[0]))
      |-> RXD_O == !$past(BUS_DOMINANT_I, 3)) else $error("receive level wrong");
   txd_pullup_a: assert property (
      TXD_PULLUP_O == (ACTIVE_MODE_O == 2'h1)) else $error("pull-up wrong");
   sleep_pins_a: assert property (
      !ACTIVE_MODE_O[0] |-> BUS_PULLDOWN_O && !RXD_O && !DRV_ON_O)
      else $error("sleep pins wrong");
   recv_on_a: assert property (
      RECV_ON_O == ACTIVE_MODE_O[0]) else $error("receiver enable wrong");
   wake_flag_a: assert property (
      WAKE_CAPABLE_O == (ACTIVE_MODE_O == 2'h2)) else $error("wake flag wrong");
   lpo_mode_a: assert property (
      LOW_POWER_OFF_STATE_I[*5] |-> ACTIVE_MODE_O == (MODE_O == 2'h0 ? 2'h0 : 2'h2))
      else $error("forced sleep wrong");
   lpo_hold_a: assert property (
      LOW_POWER_OFF_STATE_I[*4] |-> $stable(MODE_O)) else $error("field changed");
   mode_restore_a: assert property (
      (!LOW_POWER_OFF_STATE_I)[*5] |-> ACTIVE_MODE_O == $past(MODE_O))
      else $error("not restored");
endmodule // ctmc_props

// ### verification/ctmc_ctrl_model.sv
// Protocol controller stand-in driving the transmit pin.
// Assumes the bench picks each bit; it launches on the falling edge.
`timescale 1ns/1ps
module ctmc_ctrl_model
(
   input  wire logic clk_i,
   input  wire logic bit_i,
   output logic      txd_o
);
   initial txd_o = 1'b1;
   always @(negedge clk_i) txd_o <= bit_i;
endmodule // ctmc_ctrl_model

// ### verification/ctmc_top_tb.sv
// Self-checking bench for the CAN mode control block.
// Assumes the checker and controller model are compiled first.
`timescale 1ns/1ps
module ctmc_top_tb;
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin mismatches++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
   logic       clk = 1'b0, rstn = 1'b0, we = 1'b0, lpo = 1'b0, bus = 1'b0, tb = 1'b1;
   logic [1:0] wd = 2'h0, m, mo, am;
   logic       txd, rxd, rpd, tpu, tpd, drv, rcv, bpd, wk;
   logic [3:0] r;
   int         mismatches = 0, n_checks = 0, seed = 32'hd9e7a505;
   ctmc_top ctmc_top_inst (.CLK_I(clk), .RESETN_I(rstn), .MODE_WDATA_I(wd), .MODE_WE_I(we),
      .LOW_POWER_OFF_STATE_I(lpo), .TXD_I(txd), .BUS_DOMINANT_I(bus), .MODE_O(mo),
      .ACTIVE_MODE_O(am), .RXD_O(rxd), .RXD_PULLDOWN_O(rpd), .TXD_PULLUP_O(tpu),
      .TXD_PULLDOWN_O(tpd), .DRV_ON_O(drv), .RECV_ON_O(rcv), .BUS_PULLDOWN_O(bpd),
      .WAKE_CAPABLE_O(wk));
   ctmc_ctrl_model ctmc_ctrl_model_inst (.clk_i(clk), .bit_i(tb), .txd_o(txd));
   initial forever #25 clk = ~clk;
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   function automatic logic exp_drv(input logic [1:0] md, input logic tx);
      return md == 2'h3 && !tx;
   endfunction
   function automatic logic exp_rxd(input logic [1:0] md, input logic dom);
      return md[0] && !dom;
   endfunction
   function automatic logic [1:0] exp_lpo(input logic [1:0] md);
      return (md == 2'h0) ? 2'h0 : 2'h2;
   endfunction
   task automatic chk_reset;
      `CHK(mo, 2'h0)
      `CHK(am, 2'h0)
      `CHK(({bpd, tpd, rpd, rcv, drv, wk, tpu, rxd}), 8'he0)
   endtask
   initial
   begin
      #100000;
      mismatches++;
      print_verdict;
   end
   initial
   begin
      repeat (10) @(negedge clk);
      rstn = 1'b1;
      repeat (2) @(negedge clk);
      chk_reset;
      for (int i = 0; i < 8; i++)
      begin
         r = 4'($random(seed));
         m = (i < 4) ? i[1:0] : r[1:0];
         @(negedge clk);
         wd = m;
         we = 1'b1;
         @(negedge clk);
         we = 1'b0;
         repeat (6)
         begin
            r = 4'($random(seed));
            tb <= r[0];
            bus = r[1];
            wd = r[3:2];
            repeat (5) @(negedge clk);
            `CHK(drv, exp_drv(m, r[0]))
            `CHK(rxd, exp_rxd(m, r[1]))
            `CHK(tpu, m == 2'h1)
            `CHK(({bpd, tpd, rpd, rcv}), ({{3{!m[0]}}, m[0]}))
            `CHK(mo, m)
         end
         lpo = 1'b1;
         repeat (3) @(negedge clk);
         wd = ~m;
         we = 1'b1;
         repeat (3) @(negedge clk);
         we = 1'b0;
         `CHK(mo, m)
         `CHK(am, exp_lpo(m))
         `CHK(({wk, bpd, drv, rxd}), ({m != 2'h0, 3'h4}))
         `CHK(({rcv, tpu}), 2'h0)
         lpo = 1'b0;
         repeat (6) @(negedge clk);
         `CHK(am, m)
         `CHK(drv, exp_drv(m, tb))
         `CHK(rxd, exp_rxd(m, bus))
         `CHK(rcv, m[0])
         $display("mode %h done", m);
      end
      rstn = 1'b0;
      @(negedge clk);
      chk_reset;
      rstn = 1'b1;
      repeat (2) @(negedge clk);
      chk_reset;
      $display("second reset done");
      print_verdict;
   end
endmodule // ctmc_top_tb
bind ctmc_top ctmc_props ctmc_props_inst (.CLK_I(CLK_I), .RESETN_I(RESETN_I),
   .LOW_POWER_OFF_STATE_I(LOW_POWER_OFF_STATE_I), .TXD_I(TXD_I),
   .BUS_DOMINANT_I(BUS_DOMINANT_I), .MODE_O(MODE_O), .ACTIVE_MODE_O(ACTIVE_MODE_O),
   .RXD_O(RXD_O), .TXD_PULLUP_O(TXD_PULLUP_O), .DRV_ON_O(DRV_ON_O),
   .RECV_ON_O(RECV_ON_O), .BUS_PULLDOWN_O(BUS_PULLDOWN_O),
   .WAKE_CAPABLE_O(WAKE_CAPABLE_O));
